// ===== core/fcx_map.svh
// Offsets, field positions, reset values and timing counts for the FIFO array controller.
`ifndef FCX_MAP_SVH
`define FCX_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the command port)
// ----------------------------------------------------------------------------
`define FCX_REG_CTRL        4'h0
`define FCX_REG_STATUS      4'h1
`define FCX_REG_WDATA       4'h2
`define FCX_REG_RDATA       4'h3
`define FCX_REG_COUNT       4'h4

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FCX_CTRL_MODE_LSB   0
`define FCX_CTRL_RESET_BIT  2
`define FCX_CTRL_RT_BIT     3
`define FCX_CTRL_RESET_VAL  32'h0000_0000

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define FCX_ST_EMPTY_BIT    0
`define FCX_ST_HALF_BIT     1
`define FCX_ST_FULL_BIT     2
`define FCX_ST_BUSY_BIT     3
`define FCX_ST_RDV_BIT      4
`define FCX_ST_REFUSED_BIT  5

// ----------------------------------------------------------------------------
// Pulse timing, slowest grade, in ns and in 10 ns cycles
// ----------------------------------------------------------------------------
`define FCX_CLK_NS          10
`define FCX_T_PW_NS         80
`define FCX_T_REC_NS        20
`define FCX_T_XI_NS         80
`define FCX_PW_CYC          ((`FCX_T_PW_NS + `FCX_CLK_NS - 1) / `FCX_CLK_NS)
`define FCX_REC_CYC         ((`FCX_T_REC_NS + `FCX_CLK_NS - 1) / `FCX_CLK_NS)
`define FCX_XI_CYC          ((`FCX_T_XI_NS + `FCX_CLK_NS - 1) / `FCX_CLK_NS)

`endif

// ===== core/fcx_pkg.sv
// Types shared by the FIFO array controller.
package fcx_pkg;

    // ------------------------------------------------------------------------
    // Array configuration and strobe sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        FCX_MODE_SINGLE = 2'b00,
        FCX_MODE_WIDTH  = 2'b01,
        FCX_MODE_DEPTH  = 2'b10,
        FCX_MODE_BOTH   = 2'b11
    } fcx_mode_e;

    typedef enum logic [2:0] {
        FCX_IDLE  = 3'b000,
        FCX_PULSE = 3'b001,
        FCX_REC   = 3'b011,
        FCX_DONE  = 3'b010
    } fcx_state_e;

    typedef enum logic [1:0] {
        FCX_OP_WRITE = 2'b00,
        FCX_OP_READ  = 2'b01,
        FCX_OP_RESET = 2'b10,
        FCX_OP_RT    = 2'b11
    } fcx_op_e;

endpackage

// ===== core/fcx_sync.sv
// Two-stage synchroniser bank for the status flags of the FIFO array.
`timescale 1ns/1ps
module fcx_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second one; flags reset to inactive high.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ===== core/fcx_ctrl.sv
// Controller that drives a chained or widened array of nine-bit FIFO devices.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "fcx_map.svh"
module fcx_ctrl
    import fcx_pkg::*;
#(
    parameter int STAGES = 3,
    parameter int DEPTH  = 512,
    parameter int DW     = 9,
    parameter int PW_CYC = `FCX_PW_CYC,
    parameter int RC_CYC = `FCX_REC_CYC
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // Command port
    input  wire logic [3:0]        cmd_addr,
    input  wire logic [31:0]       cmd_wdata,
    input  wire logic              cmd_wr,
    input  wire logic              cmd_rd,
    output logic      [31:0]       cmd_rdata,
    // Device strobes, shared by every slice of a row
    output logic                   write_n,
    output logic                   read_n,
    output logic                   fifo_reset_n,
    output logic                   retransmit_request_n,
    // Chain straps
    output logic      [STAGES-1:0] first_load_select,
    output logic                   expansion_input_n,
    // Data pins
    output logic      [DW-1:0]     data_out,
    output logic                   data_out_oe,
    input  wire logic [DW-1:0]     data_in,
    // Per-device empty and full flags and one half-full flag, active low
    input  wire logic [STAGES-1:0] empty_flag_n,
    input  wire logic [STAGES-1:0] full_flag_n,
    input  wire logic              half_full_flag_n
);

    localparam int FW = 2 * STAGES + 1;
    localparam int CW = $clog2(STAGES * DEPTH + 1);
    localparam int TW = 8;

    // ------------------------------------------------------------------------
    // Flag synchronisers
    // ------------------------------------------------------------------------
    logic [FW-1:0] flags_s;
    logic [DW-1:0] din_s;

    // Every device keeps its own empty and full pins; they meet only after this bank.
    fcx_sync #(.WIDTH(FW)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({half_full_flag_n, full_flag_n, empty_flag_n}),
        .sync_out (flags_s)
    );

    // The read bus settles long before capture, so two stages cost no data.
    fcx_sync #(.WIDTH(DW)) u_din_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (data_in),
        .sync_out (din_s)
    );

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    fcx_mode_e        mode_q;
    fcx_state_e       state_q,   state_d;
    fcx_op_e          op_q;
    logic [TW-1:0]    tmr_q;
    logic [DW-1:0]    wdata_q;
    logic [DW-1:0]    rdata_q;
    logic             rdv_q;
    logic             refused_q;
    logic [CW-1:0]    count_q;

    // ------------------------------------------------------------------------
    // Flag decode
    // ------------------------------------------------------------------------
    // Rows of chains decode like one chain; only the depth bit matters here.
    wire chained    = mode_q[1];
    // The active-low pins are ORed, so the chain reads empty or full only when
    // every stage does; a stage without the token must not stall the array.
    wire any_empty  = ~|flags_s[STAGES-1:0];
    wire any_full   = ~|flags_s[2*STAGES-1:STAGES];
    // One device speaks for the group in single and width modes.
    wire dev_empty  = chained ? any_empty : ~flags_s[0];
    wire dev_full   = chained ? any_full : ~flags_s[STAGES];
    wire dev_half   = chained ? 1'b0 : ~flags_s[FW-1];
    wire idle       = (state_q == FCX_IDLE);

    // Command decode.
    wire wr_ctrl    = cmd_wr && cmd_addr == `FCX_REG_CTRL;
    wire wr_wdata   = cmd_wr && cmd_addr == `FCX_REG_WDATA;
    wire rd_rdata   = cmd_rd && cmd_addr == `FCX_REG_RDATA;
    wire req_reset  = wr_ctrl && cmd_wdata[`FCX_CTRL_RESET_BIT];
    wire req_rt     = wr_ctrl && cmd_wdata[`FCX_CTRL_RT_BIT];
    // Write and read strobes are gated on the flags; a refused request is reported, not queued.
    wire ok_write   = wr_wdata && !dev_full;
    wire ok_read    = rd_rdata && !dev_empty;
    wire ok_rt      = req_rt && !chained;
    wire start      = idle && (req_reset || ok_rt || ok_write || ok_read);
    wire refuse     = (wr_wdata && (dev_full || !idle)) || (rd_rdata && (dev_empty || !idle))
                      || (req_rt && (chained || !idle)) || (req_reset && !idle);

    function automatic fcx_op_e pick_op(input logic rs, input logic rt, input logic wr);
        if (rs)
            return FCX_OP_RESET;
        else if (rt)
            return FCX_OP_RT;
        else if (wr)
            return FCX_OP_WRITE;
        else
            return FCX_OP_READ;
    endfunction

    // ------------------------------------------------------------------------
    // Strobe sequencer: pulse for the minimum width, then recover.
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FCX_IDLE:  if (start) state_d = FCX_PULSE;
            FCX_PULSE: if (tmr_q == TW'(PW_CYC - 1)) state_d = FCX_REC;
            FCX_REC:   if (tmr_q == TW'(RC_CYC - 1)) state_d = FCX_DONE;
            FCX_DONE:  state_d = FCX_IDLE;
            default:   state_d = FCX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= FCX_IDLE;
            tmr_q   <= '0;
        end else begin
            state_q <= state_d;
            tmr_q   <= (state_d != state_q) ? '0 : tmr_q + TW'(1);
        end
    end

    // Operation latch and data capture.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op_q    <= FCX_OP_WRITE;
            wdata_q <= '0;
            rdata_q <= '0;
        end else begin
            if (start)
                op_q <= pick_op(req_reset, ok_rt, ok_write);
            if (ok_write && idle)
                wdata_q <= cmd_wdata[DW-1:0];
            // Take the synchronised bus on the last pulse cycle; needs PW_CYC of 3 or more.
            if (state_q == FCX_PULSE && op_q == FCX_OP_READ && tmr_q == TW'(PW_CYC - 1))
                rdata_q <= din_s;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers, all from flip-flops.
    // ------------------------------------------------------------------------
    wire pulsing = (state_d == FCX_PULSE);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            write_n              <= 1'b1;
            read_n               <= 1'b1;
            fifo_reset_n         <= 1'b1;
            retransmit_request_n <= 1'b1;
            data_out             <= '0;
            data_out_oe          <= 1'b0;
        end else begin
            // One shared strobe set serves every slice of the row.
            write_n              <= !(pulsing && pick_op(req_reset, ok_rt, ok_write) == FCX_OP_WRITE
                                      && idle || pulsing && !idle && op_q == FCX_OP_WRITE);
            read_n               <= !(pulsing && (idle ? pick_op(req_reset, ok_rt, ok_write)
                                      : op_q) == FCX_OP_READ);
            fifo_reset_n         <= !(pulsing && (idle ? pick_op(req_reset, ok_rt, ok_write)
                                      : op_q) == FCX_OP_RESET);
            retransmit_request_n <= !(pulsing && (idle ? pick_op(req_reset, ok_rt, ok_write)
                                      : op_q) == FCX_OP_RT);
            data_out             <= (ok_write && idle) ? cmd_wdata[DW-1:0] : wdata_q;
            data_out_oe          <= (state_d != FCX_IDLE)
                                    && ((idle && ok_write) || (!idle && op_q == FCX_OP_WRITE));
        end
    end

    // Straps follow the mode: token entry grounded standalone, first-load low on stage 0 when chained.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            expansion_input_n <= 1'b0;
            first_load_select <= '1;
        end else begin
            expansion_input_n <= chained;
            first_load_select <= chained ? {{(STAGES-1){1'b1}}, 1'b0} : '1;
        end
    end

    // ------------------------------------------------------------------------
    // Mode, occupancy and status
    // ------------------------------------------------------------------------
    wire done_op = (state_q == FCX_DONE);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q    <= FCX_MODE_SINGLE;
            count_q   <= '0;
            refused_q <= 1'b0;
            rdv_q     <= 1'b0;
        end else begin
            if (wr_ctrl && idle)
                mode_q <= fcx_mode_e'(cmd_wdata[`FCX_CTRL_MODE_LSB +: 2]);
            // Capacity is STAGES whole device depths when chained.
            if (done_op) begin
                unique case (op_q)
                    FCX_OP_WRITE: count_q <= count_q + CW'(1);
                    FCX_OP_READ:  count_q <= count_q - CW'(1);
                    FCX_OP_RESET: count_q <= '0;
                    FCX_OP_RT:    count_q <= count_q;
                endcase
            end
            // A new refusal wins over the clear by reading status.
            if (refuse)
                refused_q <= 1'b1;
            else if (cmd_rd && cmd_addr == `FCX_REG_STATUS)
                refused_q <= 1'b0;
            if (done_op && op_q == FCX_OP_READ)
                rdv_q <= 1'b1;
            else if (rd_rdata)
                rdv_q <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge ref_clk) begin
        if (reset)
            cmd_rdata <= '0;
        else if (cmd_rd) begin
            unique case (cmd_addr)
                `FCX_REG_CTRL:   cmd_rdata <= {30'h0, mode_q};
                `FCX_REG_STATUS: cmd_rdata <= {26'h0, refused_q, rdv_q, !idle,
                                               dev_full, dev_half, dev_empty};
                `FCX_REG_RDATA:  cmd_rdata <= {{(32-DW){1'b0}}, rdata_q};
                `FCX_REG_COUNT:  cmd_rdata <= 32'(count_q);
                default:         cmd_rdata <= 32'h0000_0000;
            endcase
        end else
            cmd_rdata <= '0;
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_low_hold;
        !write_n [*8];
    endsequence

    a_write_pulse_width: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(write_n) |-> s_low_hold)
        else $error("Write strobe shorter than minimum width.");
    a_read_pulse_width: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(read_n) |-> !read_n [*8])
        else $error("Read strobe shorter than minimum width.");
    a_no_write_full: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(write_n) |-> !$past(dev_full))
        else $error("Write strobe issued while full.");
    a_no_read_empty: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(read_n) |-> !$past(dev_empty))
        else $error("Read strobe issued while empty.");
    a_no_chain_rt: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(retransmit_request_n) |-> !$past(chained))
        else $error("Retransmit issued in depth mode.");
    a_xi_grounded: assert property (@(posedge ref_clk) disable iff (reset)
        !chained [*2] |-> !expansion_input_n)
        else $error("Expansion input not held low standalone.");
    a_first_load: assert property (@(posedge ref_clk) disable iff (reset)
        chained [*2] |-> first_load_select == {{(STAGES-1){1'b1}}, 1'b0})
        else $error("First-load straps wrong in chain.");
    a_reset_pulse: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(fifo_reset_n) |-> !fifo_reset_n [*8] ##[1:12] count_q == '0)
        else $error("Reset pulse short or count not cleared.");

    // Retransmit has the same minimum width as the data strobes.
    sequence s_rt_low_hold;
        !retransmit_request_n [*8];
    endsequence

    a_rt_pulse_width: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(retransmit_request_n) |-> s_rt_low_hold)
        else $error("Retransmit strobe shorter than minimum width.");
    a_rest_first_load: assert property (@(posedge ref_clk) disable iff (reset)
        chained [*2] |-> &first_load_select[STAGES-1:1])
        else $error("Later chain stage not held at inactive first-load.");
    a_oe_during_write: assert property (@(posedge ref_clk) disable iff (reset)
        !write_n |-> data_out_oe)
        else $error("Write strobe low while data bus not driven.");
    a_one_strobe: assert property (@(posedge ref_clk) disable iff (reset)
        $onehot0({!write_n, !read_n, !fifo_reset_n, !retransmit_request_n}))
        else $error("More than one device strobe low at once.");

endmodule

// ===== verif/fcx_dev_model.sv
// Behavioural chain of nine-bit FIFO devices facing the array controller.
`timescale 1ns/1ps
module fcx_dev_model #(
    parameter int STAGES = 2,
    parameter int DEPTH  = 4,
    parameter int DW     = 9
) (
    // Strobes and straps from the controller
    input  wire logic              write_n,
    input  wire logic              read_n,
    input  wire logic              fifo_reset_n,
    input  wire logic              retransmit_request_n,
    input  wire logic [STAGES-1:0] first_load_select,
    input  wire logic              expansion_input_n,
    input  wire logic [DW-1:0]     data_out,
    // Data and flags back to the controller
    output logic      [DW-1:0]     data_in,
    output logic      [STAGES-1:0] empty_flag_n,
    output logic      [STAGES-1:0] full_flag_n,
    output logic                   half_full_flag_n
);
    logic [DW-1:0] mem [STAGES][DEPTH];
    int            cnt [STAGES] = '{default: 0};
    int            wp  [STAGES] = '{default: 0};
    int            rp  [STAGES] = '{default: 0};
    int            wtok = 0;
    int            rtok = 0;
    int            wtot = 0;
    bit            armed = 1'b0;
    wire           chained = !first_load_select[0];

    // Reset empties every device and hands both tokens to the first one.
    always @(negedge fifo_reset_n) begin
        cnt = '{default: 0};
        wp = '{default: 0};
        rp = '{default: 0};
        wtok = 0;
        rtok = 0;
        wtot = 0;
        armed = 1'b1;
    end

    // A word lands on the rising write strobe; the last location passes the token.
    // Nothing counts before the first reset pulse, so the start-up rise is no write.
    always @(posedge write_n) begin
        if (armed && fifo_reset_n && cnt[wtok] < DEPTH) begin
            mem[wtok][wp[wtok]] = data_out;
            cnt[wtok]++;
            wtot++;
            wp[wtok] = (wp[wtok] + 1) % DEPTH;
            if (chained && wp[wtok] == 0) wtok = (wtok + 1) % STAGES;
        end
    end

    // Data shows while the read strobe is low; released bus shows the inverse.
    always @(negedge read_n) begin
        if (cnt[rtok] > 0) data_in = mem[rtok][rp[rtok]];
    end
    always @(posedge read_n) begin
        if (armed && cnt[rtok] > 0) begin
            cnt[rtok]--;
            rp[rtok] = (rp[rtok] + 1) % DEPTH;
            if (chained && rp[rtok] == 0) rtok = (rtok + 1) % STAGES;
        end
        data_in = ~data_in;
    end

    // Retransmit rewinds the read side only; chained devices ignore it.
    always @(negedge retransmit_request_n) begin
        if (!chained) begin
            rp[0] = 0;
            cnt[0] = (wtot > DEPTH) ? DEPTH : wtot;
        end
    end

    // Empty and full follow each device's own occupancy, active low; half-full follows device 0, held high when chained.
    for (genvar k = 0; k < STAGES; k++) begin : g_flag
        assign empty_flag_n[k] = (cnt[k] != 0);
        assign full_flag_n[k]  = (cnt[k] != DEPTH);
    end
    assign half_full_flag_n = chained ? 1'b1 : !(cnt[0] > DEPTH / 2);
    initial data_in = '0;
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the FIFO array controller and its device chain.
`timescale 1ns/1ps
`include "fcx_map.svh"
module testbench;
    import fcx_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  cmd_addr = '0;
    logic [31:0] cmd_wdata = '0;
    logic        cmd_wr = 1'b0;
    logic        cmd_rd = 1'b0;
    logic [31:0] cmd_rdata;
    logic        write_n, read_n, fifo_reset_n, retransmit_request_n;
    logic [1:0]  first_load_select, empty_flag_n, full_flag_n;
    logic        expansion_input_n, data_out_oe, half_full_flag_n;
    logic [8:0]  data_out, data_in;
    int          bad_count = 0;
    int          compares = 0;
    logic [31:0] v;

    always #5 ref_clk = ~ref_clk;

    fcx_ctrl #(.STAGES(2), .DEPTH(4)) u_fcx_ctrl (
        .ref_clk(ref_clk), .reset(reset), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .write_n(write_n),
        .read_n(read_n), .fifo_reset_n(fifo_reset_n),
        .retransmit_request_n(retransmit_request_n), .first_load_select(first_load_select),
        .expansion_input_n(expansion_input_n), .data_out(data_out),
        .data_out_oe(data_out_oe), .data_in(data_in), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .half_full_flag_n(half_full_flag_n));

    fcx_dev_model #(.STAGES(2), .DEPTH(4)) u_fcx_dev_model (
        .write_n(write_n), .read_n(read_n), .fifo_reset_n(fifo_reset_n),
        .retransmit_request_n(retransmit_request_n), .first_load_select(first_load_select),
        .expansion_input_n(expansion_input_n), .data_out(data_out), .data_in(data_in),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .half_full_flag_n(half_full_flag_n));

    task automatic end_of_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge ref_clk);
        cmd_rd <= 1'b0;
        #1 d = cmd_rdata;
    endtask

    // Busy spans pulse, recovery and done, plus two cycles of flag sync.
    task automatic idle;
        repeat (16) @(posedge ref_clk);
    endtask

    // Status check keeps only refused, full, half and empty.
    task automatic st(input logic [31:0] e);
        logic [31:0] s;
        rd(1, s);
        chk(s & 32'h27, e);
    endtask

    // Device write, measuring the strobe width and the data it carries.
    task automatic put(input logic [31:0] d, input int pw);
        logic [31:0] n, q, o;
        n = 0;
        o = 0;
        q = d;
        wr(2, d);
        // Sampling starts on the edge that launches the strobe.
        repeat (16) begin
            #1 if (write_n === 1'b0) begin
                n++;
                q = {23'h0, data_out};
            end
            if (data_out_oe === 1'b1) o++;
            @(posedge ref_clk);
        end
        chk(n, pw);
        chk(q, d);
        chk(o, (pw == 0) ? 0 : pw + `FCX_REC_CYC + 1);
    endtask

    // RDATA read: returns the previous word and launches the next device read.
    task automatic get(input logic ck, input logic [31:0] e, input int pw);
        logic [31:0] d, n, o;
        n = 0;
        o = 0;
        rd(3, d);
        if (ck) chk(d, e);
        repeat (16) begin
            if (read_n === 1'b0) n++;
            if (data_out_oe !== 1'b0) o++;
            @(posedge ref_clk);
            #1;
        end
        chk(n, pw);
        chk(o, 0);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        idle();
        chk({28'h0, write_n, read_n, fifo_reset_n, retransmit_request_n}, 32'hF);
        chk({29'h0, expansion_input_n, first_load_select}, 32'h3);
        // The devices take no traffic before their first reset pulse.
        wr(0, 32'h4);
        idle();
        st(32'h01);
        // Standalone: fill to the limit, then one write too many.
        for (int i = 0; i < 3; i++) put(32'h10 + i, 8);
        st(32'h02);
        put(32'h13, 8);
        st(32'h06);
        put(32'h14, 0);
        st(32'h26);
        rd(4, v);
        chk(v, 32'h4);
        // Drain in order; the last launch finds the array empty.
        get(1'b0, 0, 8);
        for (int i = 0; i < 3; i++) get(1'b1, 32'h10 + i, 8);
        get(1'b1, 32'h13, 0);
        st(32'h21);
        // Retransmit brings the first word back.
        wr(0, 32'h8);
        idle();
        st(32'h06);
        get(1'b0, 0, 8);
        get(1'b1, 32'h10, 8);
        wr(0, 32'h4);
        idle();
        st(32'h01);
        // Daisy chain: straps, refused retransmit, traffic across the token.
        wr(0, 32'h2);
        idle();
        chk({29'h0, expansion_input_n, first_load_select}, 32'h6);
        wr(0, 32'hA);
        idle();
        chk({31'h0, retransmit_request_n}, 32'h1);
        st(32'h21);
        for (int i = 0; i < 3; i++) put(32'h20 + i, 8);
        get(1'b0, 0, 8);
        get(1'b1, 32'h20, 8);
        for (int i = 3; i < 6; i++) put(32'h20 + i, 8);
        st(32'h00);
        rd(4, v);
        chk(v, 32'h4);
        for (int i = 1; i < 5; i++) get(1'b1, 32'h20 + i, 8);
        get(1'b1, 32'h25, 0);
        st(32'h21);
        // Rows of chains keep the chain straps and read back their mode.
        wr(0, 32'h3);
        idle();
        chk({29'h0, expansion_input_n, first_load_select}, 32'h6);
        rd(0, v);
        chk(v, 32'h3);
        // A write issued while the previous one still runs is refused.
        wr(2, 32'h30);
        wr(2, 32'h31);
        idle();
        st(32'h20);
        rd(4, v);
        chk(v, 32'h1);
        end_of_test();
    end
endmodule
